// ### hw/crc_engine_pkg.sv
package crc_engine_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W  = 4;
    localparam int unsigned REG_W   = 8;
    localparam int unsigned WORD_W  = 16;
    localparam int unsigned FIELD_W = 4;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ACC_LOW   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ACC_HIGH  = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_TAPS_LOW  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_TAPS_HIGH = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_WORD_LOW  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_WORD_HIGH = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_0 = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_1 = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_FLAG      = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_ENABLE    = 4'h9;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTL0_GO_BIT    = 7;
    localparam int unsigned CTL0_BUSY_BIT  = 5;
    localparam int unsigned CTL0_AUG_BIT   = 4;
    localparam int unsigned CTL0_ORDER_BIT = 1;
    localparam int unsigned CTL0_FULL_BIT  = 0;
    localparam int unsigned CTL1_DATA_LENGTH_FIELD_LSB  = 0;
    localparam int unsigned CTL1_POLY_LENGTH_FIELD_LSB  = 4;
    localparam int unsigned FLAG_DONE_BIT  = 0;
    localparam int unsigned ENABLE_IRQ_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [WORD_W-1:0]  ACC_RST   = 16'h0000;
    localparam logic [WORD_W-1:0]  TAPS_RST  = 16'h0000;
    localparam logic [WORD_W-1:0]  WORD_RST  = 16'h0000;
    localparam logic [FIELD_W-1:0] FIELD_RST = 4'h0;
    localparam logic [REG_W-1:0]   RDATA_RST = 8'h00;
    localparam logic [FIELD_W-1:0] CNT_ONE   = 4'h1;

    // ------------------------------------------------------------------
    // Engine states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b01,
        ENG_SHIFT = 2'b10
    } eng_state_t;

endpackage

// ### hw/crc_bit_step.sv
`timescale 1ns/1ps
`default_nettype none

module crc_bit_step
    import crc_engine_pkg::*;
(
    input  wire logic [crc_engine_pkg::WORD_W-1:0]  acc_in,
    input  wire logic                               data_bit,
    input  wire logic [crc_engine_pkg::WORD_W-1:0]  taps,
    input  wire logic [crc_engine_pkg::FIELD_W-1:0] msb_index,
    input  wire logic                               direct,
    output logic      [crc_engine_pkg::WORD_W-1:0]  acc_out
);

    logic [WORD_W-1:0] mask;
    logic [WORD_W-1:0] poly;
    logic [WORD_W-1:0] shifted;
    logic              feedback;

    // Accumulator is n bits wide, n = msb_index + 1
    for (genvar i = 0; i < WORD_W; i++) begin : g_mask
        assign mask[i] = (i <= int'(msb_index));
    end

    // Bottom term always one, whatever the register holds
    assign poly     = {taps[WORD_W-1:1], 1'b1};
    // Direct form equals shifting n zeros after the data
    assign feedback = acc_in[msb_index] ^ (direct & data_bit);
    assign shifted  = {acc_in[WORD_W-2:0], ~direct & data_bit};
    assign acc_out  = (shifted ^ (feedback ? poly : '0)) & mask;

endmodule

`default_nettype wire

// ### hw/configurable_crc_engine.sv
`timescale 1ns/1ps
`default_nettype none

module configurable_crc_engine
    import crc_engine_pkg::*;
#(
    parameter int unsigned MAX_WIDTH = 16
) (
    input  wire logic                               clock,
    input  wire logic                               rst_b,
    input  wire logic [crc_engine_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [crc_engine_pkg::REG_W-1:0]   reg_wdata,
    input  wire logic                               reg_write,
    input  wire logic                               reg_read,
    output logic      [crc_engine_pkg::REG_W-1:0]   reg_rdata,
    input  wire logic                               scan_valid,
    input  wire logic [crc_engine_pkg::WORD_W-1:0]  scan_word,
    output logic                                    scan_ready,
    output logic                                    busy,
    output logic                                    full,
    output logic                                    check_done_irq
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // Field widths and register pairs are sized for exactly this width
    if (MAX_WIDTH != WORD_W) begin : g_bad_width
        $error("MAX_WIDTH must equal the 16-bit word width");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WORD_W-1:0]  acc;
        logic [WORD_W-1:1]  taps;
        logic [WORD_W-1:0]  word;
        logic [WORD_W-1:0]  shifter;
        logic [FIELD_W-1:0] cnt;
        eng_state_t         eng;
        logic               go;
        logic               order;
        logic               aug;
        logic [FIELD_W-1:0] data_length_field;
        logic [FIELD_W-1:0] poly_length_field;
        logic               done_flag;
        logic               irq_en;
        logic               busy_prev;
        logic [REG_W-1:0]   rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        acc:       ACC_RST,
        taps:      TAPS_RST[WORD_W-1:1],
        word:      WORD_RST,
        shifter:   WORD_RST,
        cnt:       FIELD_RST,
        eng:       ENG_IDLE,
        go:        1'b0,
        order:     1'b0,
        aug:       1'b0,
        data_length_field:      FIELD_RST,
        poly_length_field:      FIELD_RST,
        done_flag: 1'b0,
        irq_en:    1'b0,
        busy_prev: 1'b0,
        rdata:     RDATA_RST
    };

    state_t s_q;
    state_t s_d;

    // ------------------------------------------------------------------
    // Bit step
    // ------------------------------------------------------------------
    logic              data_bit;
    logic [WORD_W-1:0] step_acc;
    logic              busy_now;
    logic              word_low_write;
    logic              scan_take;

    assign busy_now       = (s_q.eng == ENG_SHIFT);
    assign word_low_write = reg_write && (reg_addr == OFS_WORD_LOW);

    // MSB first takes the top used bit, so data_length_field marks the MSB
    assign data_bit = s_q.order ? s_q.shifter[0] : s_q.shifter[s_q.data_length_field];

    crc_bit_step u_step (
        .acc_in    (s_q.acc),
        .data_bit  (data_bit),
        .taps      ({s_q.taps, 1'b0}),
        .msb_index (s_q.poly_length_field),
        .direct    (s_q.aug),
        .acc_out   (step_acc)
    );

    // ------------------------------------------------------------------
    // Scanner handshake
    // ------------------------------------------------------------------
    // A processor write to the low word register has the slot this cycle
    assign scan_ready = s_q.go && !busy_now && !word_low_write;
    assign scan_take  = scan_valid && scan_ready;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.rdata = RDATA_RST;

        // Shift one bit per clock while go is set; clearing go pauses
        if (busy_now && s_q.go) begin
            s_d.acc = step_acc;
            if (s_q.order) begin
                s_d.shifter = {1'b0, s_q.shifter[WORD_W-1:1]};
            end else begin
                s_d.shifter = {s_q.shifter[WORD_W-2:0], 1'b0};
            end
            s_d.cnt = s_q.cnt + CNT_ONE;
            // Last used bit reached: the word is done
            if (s_q.cnt == s_q.data_length_field) begin
                s_d.eng = ENG_IDLE;
            end
        end

        // Scanner word goes through the word pair into the shifter
        if (scan_take) begin
            s_d.word    = scan_word;
            s_d.shifter = scan_word;
            s_d.cnt     = FIELD_RST;
            s_d.eng     = ENG_SHIFT;
        end

        // Register writes
        if (reg_write) begin
            case (reg_addr)
                OFS_ACC_LOW: begin
                    s_d.acc[REG_W-1:0] = reg_wdata;
                end
                OFS_ACC_HIGH: begin
                    s_d.acc[WORD_W-1:REG_W] = reg_wdata;
                end
                OFS_TAPS_LOW: begin
                    s_d.taps[REG_W-1:1] = reg_wdata[REG_W-1:1];
                end
                OFS_TAPS_HIGH: begin
                    s_d.taps[WORD_W-1:REG_W] = reg_wdata;
                end
                OFS_WORD_LOW: begin
                    s_d.word[REG_W-1:0] = reg_wdata;
                    // A write while full updates the pair but starts nothing
                    if (!busy_now) begin
                        s_d.shifter = {s_q.word[WORD_W-1:REG_W], reg_wdata};
                        s_d.cnt     = FIELD_RST;
                        s_d.eng     = ENG_SHIFT;
                    end
                end
                OFS_WORD_HIGH: begin
                    s_d.word[WORD_W-1:REG_W] = reg_wdata;
                end
                OFS_CONTROL_0: begin
                    s_d.go    = reg_wdata[CTL0_GO_BIT];
                    s_d.aug   = reg_wdata[CTL0_AUG_BIT];
                    s_d.order = reg_wdata[CTL0_ORDER_BIT];
                end
                OFS_CONTROL_1: begin
                    s_d.data_length_field = reg_wdata[CTL1_DATA_LENGTH_FIELD_LSB +: FIELD_W];
                    s_d.poly_length_field = reg_wdata[CTL1_POLY_LENGTH_FIELD_LSB +: FIELD_W];
                end
                OFS_FLAG: begin
                    s_d.done_flag = reg_wdata[FLAG_DONE_BIT];
                end
                OFS_ENABLE: begin
                    s_d.irq_en = reg_wdata[ENABLE_IRQ_BIT];
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered in the next cycle only
        if (reg_read) begin
            case (reg_addr)
                OFS_ACC_LOW: begin
                    s_d.rdata = s_q.acc[REG_W-1:0];
                end
                OFS_ACC_HIGH: begin
                    s_d.rdata = s_q.acc[WORD_W-1:REG_W];
                end
                OFS_TAPS_LOW: begin
                    s_d.rdata = {s_q.taps[REG_W-1:1], 1'b0};
                end
                OFS_TAPS_HIGH: begin
                    s_d.rdata = s_q.taps[WORD_W-1:REG_W];
                end
                OFS_WORD_LOW: begin
                    s_d.rdata = s_q.word[REG_W-1:0];
                end
                OFS_WORD_HIGH: begin
                    s_d.rdata = s_q.word[WORD_W-1:REG_W];
                end
                OFS_CONTROL_0: begin
                    s_d.rdata[CTL0_GO_BIT]    = s_q.go;
                    s_d.rdata[CTL0_BUSY_BIT]  = busy_now;
                    s_d.rdata[CTL0_AUG_BIT]   = s_q.aug;
                    s_d.rdata[CTL0_ORDER_BIT] = s_q.order;
                    s_d.rdata[CTL0_FULL_BIT]  = busy_now;
                end
                OFS_CONTROL_1: begin
                    s_d.rdata[CTL1_DATA_LENGTH_FIELD_LSB +: FIELD_W] = s_q.data_length_field;
                    s_d.rdata[CTL1_POLY_LENGTH_FIELD_LSB +: FIELD_W] = s_q.poly_length_field;
                end
                OFS_FLAG: begin
                    s_d.rdata[FLAG_DONE_BIT] = s_q.done_flag;
                end
                OFS_ENABLE: begin
                    s_d.rdata[ENABLE_IRQ_BIT] = s_q.irq_en;
                end
                default: begin
                    s_d.rdata = RDATA_RST;
                end
            endcase
        end

        // ------------------------------------------------------------------
        // Completion flag
        // ------------------------------------------------------------------
        // Set after the software write so a coincident clear loses
        s_d.busy_prev = busy_now;
        if (s_q.busy_prev && !busy_now) begin
            s_d.done_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata      = s_q.rdata;
    assign busy           = busy_now;
    assign full           = busy_now;
    assign check_done_irq = s_q.done_flag && s_q.irq_en;

endmodule

`default_nettype wire

// ### verif/crc_engine_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module crc_engine_checker
    import crc_engine_pkg::*;
#(
    parameter int unsigned MAX_WIDTH = 16
) (
    input wire logic                              clock,
    input wire logic                              rst_b,
    input wire logic [crc_engine_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [crc_engine_pkg::REG_W-1:0]  reg_wdata,
    input wire logic                              reg_write,
    input wire logic                              reg_read,
    input wire logic [crc_engine_pkg::REG_W-1:0]  reg_rdata,
    input wire logic                              scan_valid,
    input wire logic [crc_engine_pkg::WORD_W-1:0] scan_word,
    input wire logic                              scan_ready,
    input wire logic                              busy,
    input wire logic                              full,
    input wire logic                              check_done_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    full_tracks_busy_a: assert property (full == busy)
        else $error("full differs from busy");
    word_write_start_a: assert property (reg_write && reg_addr == OFS_WORD_LOW && !full
        |=> busy) else $error("word write started nothing");
    irq_rise_cause_a: assert property ($rose(check_done_irq) |->
        $past(reg_write) || $past(busy) || $past(busy, 2)) else $error("irq rose uncaused");
    irq_hold_a: assert property ($fell(check_done_irq) |-> $past(reg_write))
        else $error("irq dropped without a write");
    rdata_quiet_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
        else $error("read data outside its cycle");
    scan_take_a: assert property (scan_valid && scan_ready |=> busy)
        else $error("scanner word not taken");
    ready_when_busy_a: assert property (busy |-> !scan_ready)
        else $error("ready while busy");
    ready_low_write_a: assert property (reg_write && reg_addr == OFS_WORD_LOW |-> !scan_ready)
        else $error("ready during word write");
    busy_bound_a: assert property ($rose(busy) |-> ##[1:16] !busy)
        else $error("busy too long");

    cover property ($fell(busy));
    cover property (scan_valid && scan_ready);
    cover property ($rose(check_done_irq));
endmodule

bind configurable_crc_engine crc_engine_checker #(.MAX_WIDTH(MAX_WIDTH)) u_chk (
    .clock, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .scan_valid, .scan_word, .scan_ready, .busy, .full, .check_done_irq);

`default_nettype wire

// ### verif/scan_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module scan_source_model (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        enable,
    input  wire logic        slow,
    input  wire logic [15:0] base,
    input  wire logic [3:0]  limit,
    input  wire logic        scan_ready,
    output logic             scan_valid,
    output logic [15:0]      scan_word,
    output logic [3:0]       sent
);
    logic [1:0] gap_q;

    // Word is held until ready is seen; afterwards the bus shows junk
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            scan_valid <= 1'b0;
            scan_word  <= 16'h0000;
            sent       <= 4'h0;
            gap_q      <= 2'h0;
        end else if (scan_valid && scan_ready) begin
            sent       <= sent + 4'h1;
            scan_valid <= 1'b0;
            scan_word  <= ~scan_word;
            gap_q      <= slow ? 2'h3 : 2'h0;
        end else if (gap_q != 2'h0) begin
            gap_q <= gap_q - 2'h1;
        end else if (enable && !scan_valid && sent < limit) begin
            scan_valid <= 1'b1;
            scan_word  <= base + {12'h000, sent};
        end
    end
endmodule

`default_nettype wire

// ### verif/test_configurable_crc_engine.sv
`timescale 1ns/1ps
`default_nettype none

module test_configurable_crc_engine;
    import crc_engine_pkg::*;

    logic              clock, rst_b, reg_write, reg_read, src_en, src_slow;
    logic              busy, full, check_done_irq, scan_ready, scan_valid;
    logic [ADDR_W-1:0] reg_addr;
    logic [REG_W-1:0]  reg_wdata, reg_rdata, rv;
    logic [WORD_W-1:0] scan_word, acc, exp_acc;
    logic [3:0]        sent;
    int                n_fail, num_checks;

    configurable_crc_engine #(.MAX_WIDTH(16)) DUT (.clock, .rst_b, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .scan_valid, .scan_word, .scan_ready, .busy,
        .full, .check_done_irq);
    scan_source_model src (.clock, .rst_b, .enable(src_en), .slow(src_slow),
        .base(16'h1357), .limit(4'h3), .scan_ready, .scan_valid, .scan_word, .sent);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Bus tasks and reference
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic rd_acc;
        rd(OFS_ACC_LOW);
        acc[7:0] = rv;
        rd(OFS_ACC_HIGH);
        acc[15:8] = rv;
    endtask
    task automatic setup(input logic [15:0] seed, input logic [15:0] taps,
                         input logic [7:0] c1, input logic [7:0] c0);
        wr(OFS_ACC_LOW, seed[7:0]);
        wr(OFS_ACC_HIGH, seed[15:8]);
        wr(OFS_TAPS_LOW, taps[7:0]);
        wr(OFS_TAPS_HIGH, taps[15:8]);
        wr(OFS_CONTROL_1, c1);
        wr(OFS_CONTROL_0, c0);
    endtask
    // Idle means no word shifting and no scanner word still on offer
    task automatic wait_idle;
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge clock);
            #1;
            if (busy === 1'b0 && scan_valid === 1'b0) break;
        end
        if (i == 200) begin
            n_fail++;
            stop_test();
        end
    endtask
    function automatic logic [15:0] crc_ref(input logic [15:0] a, input logic [15:0] w,
        input logic [15:0] t, input int n, input int nb, input bit lsb, input bit aug);
        logic b;
        logic fb;
        for (int i = 0; i < nb; i++) begin
            b  = lsb ? w[i] : w[nb-1-i];
            fb = a[n-1] ^ (aug & b);
            a  = {a[14:0], ~aug & b};
            if (fb) a = a ^ (t | 16'h0001);
            a = a & (16'hffff >> (16 - n));
        end
        return a;
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int s;
        {rst_b, reg_write, reg_read, src_en, src_slow} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        n_fail = 0;
        num_checks = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        for (s = 0; s < 16; s++) begin
            rd(s[3:0]);
            chk(rv, 16'h0000);
        end
        wr(OFS_TAPS_LOW, 8'h05);
        rd(OFS_TAPS_LOW);
        chk(rv, 16'h0004);
        $display("test done: registers");
        for (s = 0; s < 2; s++) begin
            setup(16'h0000, 16'h8004, 8'hf7, 8'h90 | {6'h00, s[0], 1'b0});
            wr(OFS_ENABLE, {7'h00, s[0]});
            for (int k = 3; k >= 0; k--) begin
                // High byte is junk: only eight data bits are in use
                wr(OFS_WORD_HIGH, 8'hff);
                wr(OFS_WORD_LOW, 8'(32'h55667788 >> (8 * k)));
                if (k == 3) begin
                    rd(OFS_CONTROL_0);
                    chk(rv, 8'hb1 | {6'h00, s[0], 1'b0});
                end
                wait_idle();
            end
            rd_acc();
            chk(acc, s ? 16'h6ba2 : 16'h32d6);
            rd(OFS_FLAG);
            chk(rv, 16'h0001);
            chk(check_done_irq, s[0]);
            wr(OFS_FLAG, 8'h00);
            rd(OFS_FLAG);
            chk(rv, 16'h0000);
        end
        $display("test done: augmented example");
        for (s = 0; s < 2; s++) begin
            setup(16'h00a5, 16'h0007, 8'h7b, 8'h80 | {6'h00, s[0], 1'b0});
            wr(OFS_WORD_HIGH, 8'hf3);
            wr(OFS_WORD_LOW, 8'hc9);
            wait_idle();
            rd_acc();
            exp_acc = crc_ref(16'h00a5, 16'hf3c9, 16'h0007, 8, 12, s[0], 1'b0);
            chk(acc, exp_acc);
        end
        $display("test done: plain seeded");
        wr(OFS_CONTROL_0, 8'h00);
        src_en <= 1'b1;
        wr(OFS_WORD_LOW, 8'h3c);
        repeat (4) @(posedge clock);
        #1;
        // Word is latched and pending, but nothing shifts while go is clear
        chk({full, busy, sent}, 16'h0030);
        rd_acc();
        chk(acc, exp_acc);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        src_slow <= 1'b1;
        setup(16'h0000, 16'h8004, 8'hff, 8'h90);
        wait_idle();
        rd_acc();
        exp_acc = 16'h0000;
        for (s = 0; s < 3; s++)
            exp_acc = crc_ref(exp_acc, 16'h1357 + s[15:0], 16'h8004, 16, 16, 1'b0, 1'b1);
        chk(acc, exp_acc);
        chk(sent, 16'h0003);
        $display("test done: scanner");
        stop_test();
    end
endmodule

`default_nettype wire
